// >>> core/isr_defines.vh
/*
  Constants for the instrument status reporting block: register byte offsets,
  status byte bit positions, reset values and timing counts.
  Assumes it is included by its bare name from the core/ design files.
*/
`ifndef ISR_DEFINES_VH
`define ISR_DEFINES_VH

// register byte offsets on the ahb-lite bus
`define ISR_A_STB 8'h00
`define ISR_A_SRE 8'h04
`define ISR_A_ESR 8'h08
`define ISR_A_ESE 8'h0c
`define ISR_A_LCOND 8'h10
`define ISR_A_LEVT 8'h14
`define ISR_A_LCEN 8'h18
`define ISR_A_LEEN 8'h1c
`define ISR_A_TCOND 8'h20
`define ISR_A_TEVT 8'h24
`define ISR_A_TCEN 8'h28
`define ISR_A_TEEN 8'h2c
`define ISR_A_CMD 8'h30
`define ISR_A_OPST 8'h34
`define ISR_A_ERRPUSH 8'h38
`define ISR_A_ERRPOP 8'h3c
`define ISR_A_PARAM 8'h40

// status byte bit positions
`define ISR_STB_LCOND 0
`define ISR_STB_LEVT 1
`define ISR_STB_TCOND 2
`define ISR_STB_TEVT 3
`define ISR_STB_MAV 4
`define ISR_STB_ESB 5
`define ISR_STB_MSS 6
`define ISR_STB_EAV 7

// command register bits
`define ISR_CMD_OPC 0
`define ISR_CMD_WAI 1

// standard event register: operation complete position
`define ISR_ESR_OPC 0

// reset values
`define ISR_RST_SRE 8'h00
`define ISR_RST_ESE 8'h00
`define ISR_RST_EN16 16'h0000
`define ISR_RST_PARAM 16'h0000

// error display hold time and its cycle count at the 20 mhz clock
`define ISR_ERR_SHOW_MS 3000
`define ISR_CLK_KHZ 20000
`define ISR_ERR_SHOW_CYC (`ISR_ERR_SHOW_MS * `ISR_CLK_KHZ)

// error queue shape
`define ISR_ERRQ_DEPTH 10
`define ISR_ERRQ_WIDTH 8

`endif

// >>> core/isr_evt_reg.v
/*
  Sticky event register: bits set on one-cycle pulses, whole register cleared
  by a read strobe. A set in the clearing cycle survives.
  Assumes set pulses and the clear strobe are on clk_i.
*/
`timescale 1ns/10ps
module isr_evt_reg #(
  parameter W = 16
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [W-1:0] set_i,
  input wire clr_i,
  output reg [W-1:0] evt_o
);

  // set wins over the read clear so no occurrence is lost
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      evt_o <= {W{1'b0}};
    end else begin
      evt_o <= (evt_o & ~{W{clr_i}}) | set_i;
    end
  end

endmodule

// >>> core/isr_err_fifo.v
/*
  Error message queue: a small memory with write and read pointers and a
  registered head word. Pushes into a full queue are dropped.
  Assumes push and pop are one-cycle strobes on clk_i.
*/
`timescale 1ns/10ps
module isr_err_fifo #(
  parameter W = 8,
  parameter DEPTH = 10,
  parameter AW = 4
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire push_i,
  input wire [W-1:0] data_i,
  input wire pop_i,
  output reg [W-1:0] head_o,
  output reg [AW:0] count_o
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  wire do_push = push_i && (count_o != DEPTH[AW:0]);
  wire do_pop = pop_i && (count_o != {(AW+1){1'b0}});

  // storage, no reset needed on the array
  always @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr_q] <= data_i;
    end
  end

  // pointers wrap at depth, not at a power of two
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_o <= {(AW+1){1'b0}};
      head_o <= {W{1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      end
      count_o <= count_o + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      head_o <= mem[rd_ptr_q];
    end
  end

endmodule

// >>> core/isr_top.v
/*
  Status reporting and operation-complete logic of a laser current and
  temperature controller, reached by software over ahb-lite.
  Assumes one 20 mhz clock, synchronous active-high reset, and that all
  device-state inputs come from pins outside this clock domain.
*/
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "isr_defines.vh"
module isr_top #(
  parameter [31:0] ERR_SHOW_CYC = `ISR_ERR_SHOW_CYC,
  parameter ERRQ_DEPTH = `ISR_ERRQ_DEPTH
) (
  input wire clk_i,
  input wire sys_rst_i,
  // ahb-lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  // device state, asynchronous pins
  input wire laser_idle_i,
  input wire tec_idle_i,
  input wire nvm_busy_i,
  input wire calib_active_i,
  input wire laser_on_i,
  input wire laser_in_tol_i,
  input wire tec_on_i,
  input wire tec_in_tol_i,
  input wire outq_nonempty_i,
  input wire laser_meas_new_i,
  input wire tec_meas_new_i,
  input wire [15:0] laser_condition_query_i,
  input wire [15:0] tec_cond_i,
  input wire [15:0] laser_evt_i,
  input wire [15:0] tec_evt_i,
  input wire [6:0] std_evt_i,
  // results
  output reg srq_o,
  output reg wai_block_o,
  output reg err_display_o,
  output reg [7:0] err_code_o,
  output reg [15:0] param_value_o,
  output reg nvm_wr_req_o
);

  localparam SW = 82;

  // pin synchroniser: stage 1 feeds only stage 2; stage 3 is for edges
  reg [SW-1:0] pin_s1_q;
  reg [SW-1:0] pin_s2_q;
  reg [SW-1:0] pin_s3_q;
  wire [SW-1:0] pin_raw = {std_evt_i, tec_evt_i, laser_evt_i, tec_cond_i, laser_condition_query_i, tec_meas_new_i,
    laser_meas_new_i, outq_nonempty_i, tec_in_tol_i, tec_on_i, laser_in_tol_i, laser_on_i,
    calib_active_i, nvm_busy_i, tec_idle_i, laser_idle_i};
  wire [SW-1:0] pin_rise = pin_s2_q & ~pin_s3_q;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_s1_q <= {SW{1'b0}};
      pin_s2_q <= {SW{1'b0}};
      pin_s3_q <= {SW{1'b0}};
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // named views of the synchronised pins
  wire s_laser_idle = pin_s2_q[0];
  wire s_tec_idle = pin_s2_q[1];
  wire s_nvm_busy = pin_s2_q[2];
  wire s_calib = pin_s2_q[3];
  wire s_laser_on = pin_s2_q[4];
  wire s_laser_tol = pin_s2_q[5];
  wire s_tec_on = pin_s2_q[6];
  wire s_tec_tol = pin_s2_q[7];
  wire s_outq = pin_s2_q[8];
  wire p_laser_meas = pin_rise[9];
  wire p_tec_meas = pin_rise[10];
  wire [15:0] s_laser_condition_query = pin_s2_q[26:11];
  wire [15:0] s_tec_cond = pin_s2_q[42:27];
  wire [15:0] p_laser_evt = pin_rise[58:43];
  wire [15:0] p_tec_evt = pin_rise[74:59];
  wire [6:0] p_std_evt = pin_rise[81:75];

  // bus state
  reg op_q;
  reg wr_q;
  reg [7:0] addr_q;
  wire take = hsel_i && htrans_i[1] && hready_i;
  wire do_wr = op_q && wr_q;
  wire do_rd = op_q && !wr_q;

  // software registers
  reg [7:0] sre_q;
  reg [7:0] ese_q;
  reg [15:0] lcen_q;
  reg [15:0] leen_q;
  reg [15:0] tcen_q;
  reg [15:0] teen_q;
  reg opc_armed_q;
  reg nop_q;
  reg fresh_laser_q;
  reg fresh_tec_q;
  reg [31:0] disp_cnt_q;
  reg [7:0] stb_q;

  wire [15:0] laser_evt;
  wire [15:0] tec_evt;
  wire [7:0] std_evt;
  wire [7:0] err_head;
  wire [4:0] err_count;

  // bus strobes: reads that clear sticky registers or pop the queue, and command, push and parameter writes
  wire rd_levt = do_rd && (addr_q == `ISR_A_LEVT);
  wire rd_tevt = do_rd && (addr_q == `ISR_A_TEVT);
  wire rd_esr = do_rd && (addr_q == `ISR_A_ESR);
  wire rd_pop = do_rd && (addr_q == `ISR_A_ERRPOP);
  wire wr_cmd = do_wr && (addr_q == `ISR_A_CMD);
  wire wr_push = do_wr && (addr_q == `ISR_A_ERRPUSH);
  wire wr_param = do_wr && (addr_q == `ISR_A_PARAM);

  // operation complete fires only when armed, with the no-operation-pending flag set and calibration off
  wire opc_set = opc_armed_q && nop_q && !s_calib;

  // the three event registers
  isr_evt_reg #(
    .W(16)
  ) u_laser_evt (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(p_laser_evt),
    .clr_i(rd_levt),
    .evt_o(laser_evt)
  );

  isr_evt_reg #(
    .W(16)
  ) u_tec_evt (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(p_tec_evt),
    .clr_i(rd_tevt),
    .evt_o(tec_evt)
  );

  isr_evt_reg #(
    .W(8)
  ) u_std_evt (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i({p_std_evt, opc_set}),
    .clr_i(rd_esr),
    .evt_o(std_evt)
  );

  // error message queue, ten entries deep
  isr_err_fifo #(
    .W(`ISR_ERRQ_WIDTH),
    .DEPTH(ERRQ_DEPTH),
    .AW(4)
  ) u_err_q (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .push_i(wr_push),
    .data_i(hwdata_i[7:0]),
    .pop_i(rd_pop),
    .head_o(err_head),
    .count_o(err_count)
  );

  // ahb-lite slave: one wait state so read data leave a flip-flop
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      op_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
      if (take) begin
        op_q <= 1'b1;
        wr_q <= hwrite_i;
        addr_q <= haddr_i[7:0] & 8'hfc;
        hreadyout_o <= 1'b0;
      end else begin
        op_q <= 1'b0;
        hreadyout_o <= 1'b1;
      end
    end
  end

  // read mux; condition reads are side-effect free, unmapped reads zero
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (do_rd) begin
      case (addr_q)
        `ISR_A_STB: hrdata_o <= {24'h00_0000, stb_q};
        `ISR_A_SRE: hrdata_o <= {24'h00_0000, sre_q};
        `ISR_A_ESR: hrdata_o <= {24'h00_0000, std_evt};
        `ISR_A_ESE: hrdata_o <= {24'h00_0000, ese_q};
        `ISR_A_LCOND: hrdata_o <= {16'h0000, s_laser_condition_query};
        `ISR_A_LEVT: hrdata_o <= {16'h0000, laser_evt};
        `ISR_A_LCEN: hrdata_o <= {16'h0000, lcen_q};
        `ISR_A_LEEN: hrdata_o <= {16'h0000, leen_q};
        `ISR_A_TCOND: hrdata_o <= {16'h0000, s_tec_cond};
        `ISR_A_TEVT: hrdata_o <= {16'h0000, tec_evt};
        `ISR_A_TCEN: hrdata_o <= {16'h0000, tcen_q};
        `ISR_A_TEEN: hrdata_o <= {16'h0000, teen_q};
        `ISR_A_OPST: hrdata_o <= {28'h000_0000, err_display_o, wai_block_o, opc_armed_q, nop_q};
        `ISR_A_ERRPOP: hrdata_o <= {19'h0_0000, err_count, err_head};
        `ISR_A_PARAM: hrdata_o <= {16'h0000, param_value_o};
        default: hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // enable registers; only the low byte of sre exists so 0..255 fit
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      sre_q <= `ISR_RST_SRE;
      ese_q <= `ISR_RST_ESE;
      lcen_q <= `ISR_RST_EN16;
      leen_q <= `ISR_RST_EN16;
      tcen_q <= `ISR_RST_EN16;
      teen_q <= `ISR_RST_EN16;
    end else if (do_wr) begin
      case (addr_q)
        `ISR_A_SRE: sre_q <= hwdata_i[7:0];
        `ISR_A_ESE: ese_q <= hwdata_i[7:0];
        `ISR_A_LCEN: lcen_q <= hwdata_i[15:0];
        `ISR_A_LEEN: leen_q <= hwdata_i[15:0];
        `ISR_A_TCEN: tcen_q <= hwdata_i[15:0];
        `ISR_A_TEEN: teen_q <= hwdata_i[15:0];
        default: sre_q <= sre_q;
      endcase
    end
  end

  // parameter value takes effect on the write; nvm copy is queued outside
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      param_value_o <= `ISR_RST_PARAM;
      nvm_wr_req_o <= 1'b0;
    end else begin
      nvm_wr_req_o <= wr_param;
      if (wr_param) begin
        param_value_o <= hwdata_i[15:0];
      end
    end
  end

  // fresh measurement flags: any new command makes old readings stale
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      fresh_laser_q <= 1'b1;
      fresh_tec_q <= 1'b1;
    end else begin
      if (p_laser_meas) begin
        fresh_laser_q <= 1'b1;
      end else if (wr_cmd || wr_param) begin
        fresh_laser_q <= 1'b0;
      end
      if (p_tec_meas) begin
        fresh_tec_q <= 1'b1;
      end else if (wr_cmd || wr_param) begin
        fresh_tec_q <= 1'b0;
      end
    end
  end

  // no-operation-pending: all nine completion criteria at once
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      nop_q <= 1'b0;
    end else begin
      nop_q <= s_laser_idle && s_tec_idle
        && !s_nvm_busy
        && fresh_laser_q && fresh_tec_q
        && (disp_cnt_q == 32'h0000_0000) && !s_calib
        && (!s_laser_on || s_laser_tol) && (!s_tec_on || s_tec_tol)
        && !wr_cmd && !wr_param;
    end
  end

  // opc and wait commands; commands never stall the bus, they overlap
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      opc_armed_q <= 1'b0;
      wai_block_o <= 1'b0;
    end else begin
      if (wr_cmd && hwdata_i[`ISR_CMD_OPC]) begin
        opc_armed_q <= 1'b1;
      end else if (opc_set) begin
        opc_armed_q <= 1'b0;
      end
      if (wr_cmd && hwdata_i[`ISR_CMD_WAI]) begin
        wai_block_o <= 1'b1;
      end else if (nop_q && !s_calib) begin
        wai_block_o <= 1'b0;
      end
    end
  end

  // error display: each new error restarts the hold so it shows at once
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      disp_cnt_q <= 32'h0000_0000;
      err_display_o <= 1'b0;
      err_code_o <= 8'h00;
    end else begin
      if (wr_push) begin
        disp_cnt_q <= ERR_SHOW_CYC;
        err_display_o <= 1'b1;
        err_code_o <= hwdata_i[7:0];
      end else if (disp_cnt_q != 32'h0000_0000) begin
        disp_cnt_q <= disp_cnt_q - 32'h0000_0001;
        err_display_o <= (disp_cnt_q != 32'h0000_0001);
      end
    end
  end

  // status byte summary bits from masked registers, the output queue pin and the error count
  wire [7:0] stb_base;
  assign stb_base[`ISR_STB_LCOND] = |(s_laser_condition_query & lcen_q);
  assign stb_base[`ISR_STB_LEVT] = |(laser_evt & leen_q);
  assign stb_base[`ISR_STB_TCOND] = |(s_tec_cond & tcen_q);
  assign stb_base[`ISR_STB_TEVT] = |(tec_evt & teen_q);
  assign stb_base[`ISR_STB_MAV] = s_outq;
  assign stb_base[`ISR_STB_ESB] = |(std_evt & ese_q);
  assign stb_base[`ISR_STB_MSS] = 1'b0;
  assign stb_base[`ISR_STB_EAV] = (err_count != 5'h00);
  wire mss = |(stb_base & sre_q);

  // registered status byte and service request
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      stb_q <= 8'h00;
      srq_o <= 1'b0;
    end else begin
      stb_q <= stb_base | ({7'h00, mss} << `ISR_STB_MSS);
      srq_o <= mss;
    end
  end

endmodule

// >>> tb/isr_top_asserts.sv
/*
  Checker for isr_top: bus wait state, parameter write, error display time
  and the wait flag. Assumes binding to isr_top with its show-time parameter.
*/
`timescale 1ns/10ps
`include "isr_defines.vh"
module isr_top_asserts #(
  parameter [31:0] ERR_SHOW_CYC = 32'd20
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  input wire hreadyout_o,
  input wire nvm_busy_i,
  input wire calib_active_i,
  input wire wai_block_o,
  input wire err_display_o,
  input wire [15:0] param_value_o,
  input wire nvm_wr_req_o
);
  wire tk = hsel_i & htrans_i[1] & hready_i;
  wire tk_push = tk & hwrite_i & (haddr_i[7:0] == `ISR_A_ERRPUSH);
  reg [31:0] show_q;
  // display age; a push restarts it, so slack of three covers the bus lag
  always @(posedge clk_i) begin
    if (sys_rst_i || !err_display_o || tk_push) show_q <= 32'h0;
    else show_q <= show_q + 32'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_ready_wait; tk |=> !hreadyout_o ##1 hreadyout_o; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("bus wait state not one cycle");
  property p_param; tk && hwrite_i && haddr_i[7:0] == `ISR_A_PARAM
    |=> ##1 nvm_wr_req_o && param_value_o == $past(hwdata_i[15:0]); endproperty
  a_param: assert property (p_param) else $error("parameter not applied with write request");
  property p_nvm_pulse; nvm_wr_req_o |=> !nvm_wr_req_o; endproperty
  a_nvm_pulse: assert property (p_nvm_pulse) else $error("write request longer than a pulse");
  property p_push_show; tk_push |=> ##1 err_display_o; endproperty
  a_push_show: assert property (p_push_show) else $error("new error not shown at once");
  property p_show_max; err_display_o |-> show_q <= ERR_SHOW_CYC + 32'd3; endproperty
  a_show_max: assert property (p_show_max) else $error("error display held too long");
  property p_show_min; $fell(err_display_o) |-> show_q + 32'd3 >= ERR_SHOW_CYC; endproperty
  a_show_min: assert property (p_show_min) else $error("error display dropped early");
  property p_wai_nvm; nvm_busy_i [*6] |=> !$fell(wai_block_o); endproperty
  a_wai_nvm: assert property (p_wai_nvm) else $error("wait released during memory write");
  property p_wai_cal; calib_active_i [*6] |=> !$fell(wai_block_o); endproperty
  a_wai_cal: assert property (p_wai_cal) else $error("wait released during calibration");
endmodule

// >>> tb/isr_ahb_host.sv
/*
  Host model: an ahb-lite master making single word transfers.
  Assumes one slave whose hreadyout is fed back as hready_i.
*/
`timescale 1ns/10ps
module isr_ahb_host (
  input wire clk_i,
  input wire hready_i,
  output reg hsel_o = 1'b0,
  output reg [31:0] haddr_o = 32'h0,
  output reg [1:0] htrans_o = 2'b00,
  output reg hwrite_o = 1'b0,
  output reg [2:0] hsize_o = 3'b010,
  output reg [31:0] hwdata_o = 32'h0
);
  // released lines show inverted values so stale data never looks valid
  task xfer(input [31:0] a, input w, input [31:0] d);
    begin
      @(posedge clk_i);
      hsel_o <= 1'b1;
      haddr_o <= a;
      htrans_o <= 2'b10;
      hwrite_o <= w;
      do @(posedge clk_i); while (!hready_i);
      htrans_o <= 2'b00;
      hwdata_o <= w ? d : ~hwdata_o;
      do @(posedge clk_i); while (!hready_i);
      hsel_o <= 1'b0;
      haddr_o <= ~a;
      hwdata_o <= ~hwdata_o;
    end
  endtask
endmodule

// >>> tb/tb_isr_top.sv
/*
  Bench for isr_top: host model on the bus, device pins from the bench,
  reads checked against a queue of notes. Assumes a 20 mhz clock.
*/
`timescale 1ns/10ps
`include "isr_defines.vh"
module tb_isr_top;
  localparam SHOW = 40;
  reg clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  wire hsel, hwrite, hrdy, hresp, srq, wai, disp, nreq;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [31:0] haddr, hwdata, hrdata;
  wire [7:0] ecode;
  wire [15:0] pval;
  reg lidle = 1'b1, tidle = 1'b1, nbusy = 1'b0, calib = 1'b0, lon = 1'b0, ltol = 1'b0;
  reg ton = 1'b1, ttol = 1'b1, outq = 1'b0, lmeas = 1'b0, tmeas = 1'b0;
  reg [15:0] lcond = 16'h0, tcond = 16'h0, levt = 16'h0, tevt = 16'h0;
  reg [6:0] sevt = 7'h0;
  reg [31:0] rng = 32'd55175;
  reg [63:0] q [$];
  reg [63:0] e;
  reg rd_pend = 1'b0;
  reg [15:0] v;
  integer mismatches = 0, compares = 0, i, k, n, t = 0;
  always #25 clk_i = ~clk_i;
  isr_ahb_host u_host (.clk_i(clk_i), .hready_i(hrdy), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
    .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));
  isr_top #(.ERR_SHOW_CYC(SHOW)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .laser_idle_i(lidle), .tec_idle_i(tidle),
    .nvm_busy_i(nbusy), .calib_active_i(calib), .laser_on_i(lon), .laser_in_tol_i(ltol), .tec_on_i(ton),
    .tec_in_tol_i(ttol), .outq_nonempty_i(outq), .laser_meas_new_i(lmeas), .tec_meas_new_i(tmeas),
    .laser_condition_query_i(lcond), .tec_cond_i(tcond), .laser_evt_i(levt), .tec_evt_i(tevt), .std_evt_i(sevt),
    .srq_o(srq), .wai_block_o(wai), .err_display_o(disp), .err_code_o(ecode), .param_value_o(pval),
    .nvm_wr_req_o(nreq));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // the oldest note is matched to each read data phase as it ends
  always @(posedge clk_i) begin
    if (hrdy) begin
      if (rd_pend) begin
        e = q.pop_front();
        chk(hrdata & e[63:32], e[31:0]);
        chk({31'h0, hresp}, 32'h0);
      end
      rd_pend <= hsel & htrans[1] & !hwrite;
    end
  end
  task cyc(input integer c);
    repeat (c) @(posedge clk_i);
  endtask
  task wr(input [31:0] a, input [31:0] d);
    u_host.xfer(a, 1'b1, d);
  endtask
  task rx(input [31:0] a, input [31:0] x, input [31:0] m);
    begin
      q.push_back({m, x});
      u_host.xfer(a, 1'b0, 32'h0);
    end
  endtask
  // xorshift step; the seed is fixed so every run sees the same values
  function [31:0] xs(input [31:0] s);
    reg [31:0] r;
    begin
      r = s ^ (s << 13);
      r = r ^ (r >> 17);
      xs = r ^ (r << 5);
    end
  endfunction
  task nxt;
    rng = xs(rng);
  endtask
  task endt;
    begin
      t = t + 1;
      $display("test %0d done", t);
    end
  endtask
  // index names the one completion criterion held bad; 99 means all good
  task pins(input integer b);
    begin
      lidle <= b != 0;
      tidle <= b != 1;
      nbusy <= b == 2;
      calib <= b == 5;
      lon <= b == 6;
      ttol <= b != 7;
    end
  endtask
  task meas(input integer b);
    begin
      lmeas <= b != 3;
      tmeas <= b != 4;
      cyc(3);
      lmeas <= 1'b0;
      tmeas <= 1'b0;
      cyc(1);
    end
  endtask
  task results;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    #(50 * 30000);
    mismatches = mismatches + 1;
    results;
  end
  initial begin
    cyc(5);
    sys_rst_i <= 1'b0;
    cyc(1);
    rx(`ISR_A_SRE, 0, 32'hffffffff);
    rx(`ISR_A_PARAM, 0, 32'hffffffff);
    wr(`ISR_A_SRE, 32'hff);
    rx(`ISR_A_SRE, 32'hff, 32'hffffffff);
    wr(`ISR_A_SRE, 0);
    nxt;
    wr(`ISR_A_PARAM, rng);
    rx(`ISR_A_PARAM, {16'h0, rng[15:0]}, 32'hffffffff);
    chk(pval, rng[15:0]);
    wr(32'h7c, rng);
    rx(32'h7c, 0, 32'hffffffff);
    endt;
    // laser block at 10, temperature block 10 above it
    for (k = 0; k < 2; k = k + 1) begin
      nxt;
      v = rng[15:0];
      if (k == 0) lcond <= v;
      else tcond <= v;
      wr(`ISR_A_LCEN + 16 * k, 32'h8000);
      wr(`ISR_A_LEEN + 16 * k, 32'h8);
      rx(`ISR_A_LCOND + 16 * k, v, 32'hffffffff);
      rx(`ISR_A_LCOND + 16 * k, v, 32'hffffffff);
      rx(`ISR_A_STB, {31'h0, v[15]} << (2 * k), 1 << (2 * k));
      if (k == 0) levt <= 16'h8;
      else tevt <= 16'h8;
      cyc(4);
      levt <= 16'h0;
      tevt <= 16'h0;
      rx(`ISR_A_STB, 2 << (2 * k), 2 << (2 * k));
      rx(`ISR_A_LEVT + 16 * k, 32'h8, 32'hffffffff);
      rx(`ISR_A_LEVT + 16 * k, 0, 32'hffffffff);
      rx(`ISR_A_STB, 0, 2 << (2 * k));
    end
    sevt <= 7'h1;
    cyc(4);
    sevt <= 7'h0;
    rx(`ISR_A_ESR, 2, 2);
    endt;
    outq <= 1'b1;
    cyc(4);
    rx(`ISR_A_STB, 32'h10, 32'h10);
    outq <= 1'b0;
    for (i = 0; i < 11; i = i + 1) wr(`ISR_A_ERRPUSH, 32'h40 + i);
    cyc(1);
    chk(ecode, 32'h4a);
    chk(disp, 1);
    rx(`ISR_A_STB, 32'h80, 32'h90);
    for (i = 0; i < 10; i = i + 1) rx(`ISR_A_ERRPOP, ((10 - i) << 8) + 32'h40 + i, 32'h1fff);
    rx(`ISR_A_STB, 0, 32'h80);
    cyc(SHOW + 4);
    chk(disp, 0);
    endt;
    // the host arms completion with both enables set before the command
    wr(`ISR_A_ESE, 1);
    wr(`ISR_A_SRE, 32'h20);
    for (i = 0; i < 9; i = i + 1) begin
      pins(i);
      if (i == 8) wr(`ISR_A_ERRPUSH, 32'h5a);
      wr(`ISR_A_CMD, 32'h3);
      meas(i);
      cyc(12);
      chk(srq, 0);
      chk(wai, 1);
      pins(99);
      meas(99);
      n = 0;
      while (srq !== 1'b1 && n < 60) begin
        cyc(1);
        n = n + 1;
      end
      cyc(2);
      chk(srq, 1);
      chk(wai, 0);
      rx(`ISR_A_STB, 32'h60, 32'h60);
      rx(`ISR_A_ESR, 1, 1);
      rx(`ISR_A_ESR, 0, 1);
      chk(srq, 0);
    end
    endt;
    cyc(2);
    results;
  end
endmodule
bind isr_top isr_top_asserts #(.ERR_SHOW_CYC(ERR_SHOW_CYC)) u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hreadyout_o(hreadyout_o), .nvm_busy_i(nvm_busy_i), .calib_active_i(calib_active_i),
  .wai_block_o(wai_block_o), .err_display_o(err_display_o), .param_value_o(param_value_o),
  .nvm_wr_req_o(nvm_wr_req_o));
